// ---- verilog/umsb_top.sv ----
/*
 UART core: modem control with loopback, line and modem status, FIFO counters, fractional baud divisor.
 Assumes a byte-wide register port with one-cycle read and write strobes, inputs async to ref_clk.
*/
// Functional notes
// - Loopback holds output high, wraps serial data
// - Loopback wraps modem outputs to inputs
// - Modem outputs follow control bits one, zero outside loopback
// - Error summary bit seven set
// - All-empty bit six tracks transmitter
// - Transmit FIFO empty bit five
// - Break flag on all-zero character
// - Framing error on missing stop bit
// - Parity error on failed check
// - Overrun when receive storage is full
// - Data ready from receive FIFO state
// - Status read clears error flags
// - Modem levels inverted, or loopback sources
// - Ring rise edge sets bit two
// - Receive fill count at eight
// - Transmit fill count at nine
// - Divisor bytes need select bit seven
`timescale 1ns/10ps
`default_nettype none
`include "umsb_cfg.svh"
module umsb_top (
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   input  wire logic [3:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   output logic            txd,
   input  wire logic       rxd,
   output logic            rts_n,
   output logic            dtr_n,
   input  wire logic       cts_n,
   input  wire logic       dsr_n,
   input  wire logic       ri_n,
   input  wire logic       dcd_n
);
   typedef struct packed {
      logic [7:0]          div_lo;
      logic [7:0]          div_hi;
      logic [7:0]          div_fr;
      logic [7:0]          lctrl;
      logic [4:0]          mctrl;
      logic [4:0]          sync1;
      logic [4:0]          sync2;
      logic [3:0]          mlev_q;
      logic [3:0]          mchg;
      logic                err_pe;
      logic                err_fe;
      logic                err_bi;
      logic                err_oe;
      logic [15:0]         bcnt;
      logic [8:0]          facc;
      logic                tick;
      logic [7:0]          rdata;
      umsb_pkg::umsb_ser_t tst;
      logic [3:0]          tsub;
      logic [3:0]          tbit;
      logic [10:0]         tsh;
      logic                txo;
      umsb_pkg::umsb_ser_t rst;
      logic [3:0]          rsub;
      logic [3:0]          rbit;
      logic [9:0]          rsh;
      logic                rxin_q;
      logic [7:0]          rx_wdata;
      logic                rx_push;
   } umsb_st_t;
   umsb_st_t   st_reg;
   umsb_st_t   st_next;
   logic       divsel;
   logic       loop;
   logic       ser_in;
   logic [3:0] mlev;
   logic       tx_in_ready;
   logic       tx_out_valid;
   logic [7:0] tx_out_data;
   logic       tx_pop;
   logic [7:0] tx_fill;
   logic       rx_in_ready;
   logic       rx_out_valid;
   logic [7:0] rx_out_data;
   logic       rx_pop;
   logic [7:0] rx_fill;
   logic [7:0] lstat;
   logic [7:0] mstat;
   logic [3:0] nbits;
   logic       par_calc;
   logic [7:0] rx_mask;

   assign divsel = st_reg.lctrl[`UMSB_BIT_DIVSEL];
   assign loop   = st_reg.mctrl[`UMSB_BIT_LOOP];

   assign ser_in = loop ? st_reg.txo : st_reg.sync2[4];
   assign txd    = loop ? 1'b1 : st_reg.txo;
   assign rts_n  = loop ? 1'b1 : ~st_reg.mctrl[`UMSB_BIT_RTS];
   assign dtr_n  = loop ? 1'b1 : ~st_reg.mctrl[`UMSB_BIT_DTR];
   // loopback modem wrap: dcd, ri, dsr, cts order
   assign mlev = loop ? {st_reg.mctrl[`UMSB_BIT_AUX2], st_reg.mctrl[`UMSB_BIT_AUX1],
                         st_reg.mctrl[`UMSB_BIT_DTR], st_reg.mctrl[`UMSB_BIT_RTS]}
                      : ~st_reg.sync2[3:0];

   assign nbits   = 4'h5 + {2'b00, st_reg.lctrl[1:0]};
   assign rx_mask = 8'hff >> (4'h8 - nbits);
   // data ready straight from FIFO state
   assign lstat = {st_reg.err_pe | st_reg.err_fe | st_reg.err_bi,
                   !tx_out_valid && (st_reg.tst == umsb_pkg::UMSB_IDLE),
                   !tx_out_valid, st_reg.err_bi, st_reg.err_fe, st_reg.err_pe,
                   st_reg.err_oe, rx_out_valid};
   assign mstat = {mlev, st_reg.mchg};
   assign tx_pop = tx_out_valid && (st_reg.tst == umsb_pkg::UMSB_IDLE) && st_reg.tick;
   assign rx_pop = reg_rd && (reg_addr == `UMSB_OFS_DATA) && !divsel;

   // Transmit FIFO, written from the data offset
   umsb_fifo #(.WIDTH(8), .DEPTH(`UMSB_FIFO_DEPTH)) u_txf (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .flush    (1'b0),
      .in_data  (reg_wdata),
      .in_valid (reg_wr && (reg_addr == `UMSB_OFS_DATA) && !divsel),
      .in_ready (tx_in_ready),
      .out_data (tx_out_data),
      .out_valid(tx_out_valid),
      .out_ready(tx_pop),
      .fill     (tx_fill)
   );
   // Receive FIFO, drained by data reads
   umsb_fifo #(.WIDTH(8), .DEPTH(`UMSB_FIFO_DEPTH)) u_rxf (
      .ref_clk  (ref_clk),
      .rstn     (rstn),
      .flush    (1'b0),
      .in_data  (st_reg.rx_wdata),
      .in_valid (st_reg.rx_push),
      .in_ready (rx_in_ready),
      .out_data (rx_out_data),
      .out_valid(rx_out_valid),
      .out_ready(rx_pop),
      .fill     (rx_fill)
   );
   assign reg_rdata = st_reg.rdata;

   // Next-state logic for registers, baud and serial engines
   always_comb begin
      st_next = st_reg;
      par_calc = 1'b0;
      st_next.sync1 = {rxd, dcd_n, ri_n, dsr_n, cts_n};
      st_next.sync2 = st_reg.sync1;
      st_next.rx_push = 1'b0;
      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            `UMSB_OFS_DIV_LOW:  if (divsel) st_next.div_lo = reg_wdata;
            `UMSB_OFS_DIV_HIGH: if (divsel) st_next.div_hi = reg_wdata;
            `UMSB_OFS_DIV_FRAC: if (divsel) st_next.div_fr = reg_wdata;
            `UMSB_OFS_LCTRL:    st_next.lctrl = reg_wdata;
            `UMSB_OFS_MCTRL:    st_next.mctrl = reg_wdata[4:0];
            default:            st_next.lctrl = st_reg.lctrl;
         endcase
      end
      // Read data capture
      st_next.rdata = `UMSB_RST_BYTE;
      if (reg_rd) begin
         case (reg_addr)
            `UMSB_OFS_DIV_LOW:  st_next.rdata = divsel ? st_reg.div_lo : rx_out_data;
            `UMSB_OFS_DIV_HIGH: st_next.rdata = divsel ? st_reg.div_hi : 8'h00;
            `UMSB_OFS_DIV_FRAC: st_next.rdata = divsel ? st_reg.div_fr : 8'h00;
            `UMSB_OFS_LCTRL:    st_next.rdata = st_reg.lctrl;
            `UMSB_OFS_LSTAT:    st_next.rdata = lstat;
            `UMSB_OFS_MSTAT:    st_next.rdata = mstat;
            `UMSB_OFS_RXCNT:    st_next.rdata = rx_fill;
            `UMSB_OFS_TXCNT:    st_next.rdata = tx_fill;
            default:            st_next.rdata = 8'h00;
         endcase
      end
      if (reg_rd && reg_addr == `UMSB_OFS_LSTAT) begin
         st_next.err_pe = 1'b0;
         st_next.err_fe = 1'b0;
         st_next.err_bi = 1'b0;
         st_next.err_oe = 1'b0;
      end
      // change flags clear on read, set wins
      if (reg_rd && reg_addr == `UMSB_OFS_MSTAT) begin
         st_next.mchg = 4'h0;
      end
      st_next.mlev_q = mlev;
      // delta detect on dcd, dsr, cts
      st_next.mchg[3] = st_next.mchg[3] | (mlev[3] ^ st_reg.mlev_q[3]);
      st_next.mchg[2] = st_next.mchg[2] | (mlev[2] & ~st_reg.mlev_q[2]);
      st_next.mchg[1] = st_next.mchg[1] | (mlev[1] ^ st_reg.mlev_q[1]);
      st_next.mchg[0] = st_next.mchg[0] | (mlev[0] ^ st_reg.mlev_q[0]);
      st_next.tick = 1'b0;
      if (st_reg.bcnt == 16'h0000) begin
         st_next.tick = ({st_reg.div_hi, st_reg.div_lo} != 16'h0000);
         st_next.facc = {1'b0, st_reg.facc[7:0]} + {1'b0, st_reg.div_fr};
         // Divisor zero parks the counter so a later divisor takes effect at once
         if ({st_reg.div_hi, st_reg.div_lo} == 16'h0000) begin
            st_next.bcnt = 16'h0000;
         end else begin
            st_next.bcnt = {st_reg.div_hi, st_reg.div_lo} - (st_next.facc[8] ? 16'h0000 : 16'h0001);
         end
      end else begin
         st_next.bcnt = st_reg.bcnt - 16'h0001;
      end
      // Transmit engine, 16 ticks per bit
      if (st_reg.tick) begin
         case (st_reg.tst)
            umsb_pkg::UMSB_IDLE: begin
               st_next.txo = 1'b1;
               if (tx_out_valid) begin
                  par_calc = ^(tx_out_data & rx_mask) ^ ~st_reg.lctrl[4];
                  if (st_reg.lctrl[5]) par_calc = ~st_reg.lctrl[4];
                  st_next.tsh = {2'b11, par_calc, tx_out_data} >> (4'h8 - nbits);
                  if (st_reg.lctrl[3]) st_next.tsh[nbits] = par_calc;
                  else st_next.tsh[nbits] = 1'b1;
                  st_next.tst  = umsb_pkg::UMSB_START;
                  st_next.txo  = 1'b0;
                  st_next.tsub = 4'h0;
                  st_next.tbit = 4'h0;
               end
            end
            umsb_pkg::UMSB_START, umsb_pkg::UMSB_DATA: begin
               st_next.tsub = st_reg.tsub + 4'h1;
               if (st_reg.tsub == 4'hf) begin
                  st_next.txo  = st_reg.tsh[0];
                  st_next.tsh  = {1'b1, st_reg.tsh[10:1]};
                  st_next.tbit = st_reg.tbit + 4'h1;
                  st_next.tst  = umsb_pkg::UMSB_DATA;
                  if (st_reg.tbit == nbits + {3'b000, st_reg.lctrl[3]}) begin
                     st_next.tst = umsb_pkg::UMSB_STOP;
                     st_next.txo = 1'b1;
                  end
               end
            end
            umsb_pkg::UMSB_STOP: begin
               st_next.tsub = st_reg.tsub + 4'h1;
               if (st_reg.tsub == 4'hf) begin
                  st_next.tbit = st_reg.tbit + 4'h1;
                  if (!st_reg.lctrl[2] || st_reg.tbit != nbits + {3'b000, st_reg.lctrl[3]}) begin
                     st_next.tst = umsb_pkg::UMSB_IDLE;
                  end
               end
            end
            default: st_next.tst = umsb_pkg::UMSB_IDLE;
         endcase
         if (st_reg.lctrl[6]) st_next.txo = 1'b0;
      end
      // Receive engine, sample at mid bit
      st_next.rxin_q = ser_in;
      if (st_reg.tick) begin
         case (st_reg.rst)
            umsb_pkg::UMSB_IDLE: begin
               if (!ser_in) begin
                  st_next.rst  = umsb_pkg::UMSB_START;
                  st_next.rsub = 4'h0;
               end
            end
            umsb_pkg::UMSB_START: begin
               st_next.rsub = st_reg.rsub + 4'h1;
               if (st_reg.rsub == 4'h7) begin
                  st_next.rst  = ser_in ? umsb_pkg::UMSB_IDLE : umsb_pkg::UMSB_DATA;
                  st_next.rsub = 4'h0;
                  st_next.rbit = 4'h0;
                  st_next.rsh  = 10'h000;
               end
            end
            umsb_pkg::UMSB_DATA: begin
               st_next.rsub = st_reg.rsub + 4'h1;
               if (st_reg.rsub == 4'hf) begin
                  st_next.rsh[st_reg.rbit] = ser_in;
                  st_next.rbit = st_reg.rbit + 4'h1;
                  if (st_reg.rbit == nbits + {3'b000, st_reg.lctrl[3]}) begin
                     st_next.rst = umsb_pkg::UMSB_STOP;
                  end
               end
            end
            umsb_pkg::UMSB_STOP: begin
               st_next.rst = umsb_pkg::UMSB_IDLE;
               par_calc = ^(st_reg.rsh[7:0] & rx_mask) ^ ~st_reg.lctrl[4];
               if (st_reg.lctrl[5]) par_calc = ~st_reg.lctrl[4];
               if (st_reg.lctrl[3] && (st_reg.rsh[nbits] != par_calc)) st_next.err_pe = 1'b1;
               if (!st_reg.rsh[nbits + {3'b000, st_reg.lctrl[3]}]) st_next.err_fe = 1'b1;
               // whole character zero is a break
               if (st_reg.rsh == 10'h000) st_next.err_bi = 1'b1;
               if (rx_in_ready) begin
                  st_next.rx_push  = 1'b1;
                  st_next.rx_wdata = st_reg.rsh[7:0] & rx_mask;
               end else begin
                  st_next.err_oe = 1'b1;
               end
            end
            default: st_next.rst = umsb_pkg::UMSB_IDLE;
         endcase
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg       <= '0;
         st_reg.lctrl <= `UMSB_RST_LCTRL;
         st_reg.sync1 <= 5'h1f;
         st_reg.sync2 <= 5'h1f;
         st_reg.txo   <= 1'b1;
         st_reg.tst   <= umsb_pkg::UMSB_IDLE;
         st_reg.rst   <= umsb_pkg::UMSB_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   a_loop_txd_high: assert property (@(posedge ref_clk) disable iff (!rstn)
      loop |-> txd) else $error("txd not high in loopback");
   a_loop_modem_wrap: assert property (@(posedge ref_clk) disable iff (!rstn)
      loop |-> (mstat[7:4] == {st_reg.mctrl[3], st_reg.mctrl[2], st_reg.mctrl[0], st_reg.mctrl[1]}))
      else $error("loopback modem wrap wrong");
   a_rts_dtr_drive: assert property (@(posedge ref_clk) disable iff (!rstn)
      !loop |-> (rts_n == ~st_reg.mctrl[1]) && (dtr_n == ~st_reg.mctrl[0]))
      else $error("rts or dtr not from control");
   a_err_summary: assert property (@(posedge ref_clk) disable iff (!rstn)
      lstat[7] == (lstat[4] | lstat[3] | lstat[2])) else $error("error summary wrong");
   a_all_empty_sub: assert property (@(posedge ref_clk) disable iff (!rstn)
      lstat[6] |-> lstat[5]) else $error("all empty without fifo empty");
   a_tfe_after_write: assert property (@(posedge ref_clk) disable iff (!rstn)
      (reg_wr && reg_addr == 4'h0 && !divsel && tx_in_ready) |=> !lstat[5])
      else $error("fifo empty after write");
   a_lsr_read_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
      (reg_rd && reg_addr == 4'h5 && !(st_reg.tick && st_reg.rst == umsb_pkg::UMSB_STOP))
      |=> (lstat[4:1] == 4'h0)) else $error("status read did not clear");
   a_data_ready: assert property (@(posedge ref_clk) disable iff (!rstn)
      lstat[0] == (rx_fill != 8'h00)) else $error("data ready mismatch");
   a_msr_read_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
      (reg_rd && reg_addr == 4'h6 && (mlev == st_reg.mlev_q)) |=> (st_reg.mchg == 4'h0))
      else $error("modem change not cleared");
   a_dcd_change_set: assert property (@(posedge ref_clk) disable iff (!rstn)
      (mlev[3] != st_reg.mlev_q[3]) |=> st_reg.mchg[3]) else $error("carrier change not flagged");
   a_ring_rise_set: assert property (@(posedge ref_clk) disable iff (!rstn)
      (mlev[2] && !st_reg.mlev_q[2]) |=> st_reg.mchg[2]) else $error("ring rise not flagged");
   a_overrun_set: assert property (@(posedge ref_clk) disable iff (!rstn)
      (st_reg.tick && st_reg.rst == umsb_pkg::UMSB_STOP && !rx_in_ready) |=> st_reg.err_oe)
      else $error("overrun not flagged");
   // data writes leave the divisor alone
   a_div_guarded: assert property (@(posedge ref_clk) disable iff (!rstn)
      (reg_wr && reg_addr == 4'h0 && !divsel) |=> (st_reg.div_lo == $past(st_reg.div_lo)))
      else $error("divisor written without select");
   a_lstat_read: assert property (@(posedge ref_clk) disable iff (!rstn)
      (reg_rd && reg_addr == 4'h5) |=> (reg_rdata == $past(lstat))) else $error("status read wrong");
   a_txcnt_read: assert property (@(posedge ref_clk) disable iff (!rstn)
      (reg_rd && reg_addr == 4'h9) |=> (reg_rdata == $past(tx_fill))) else $error("tx count read wrong");
   a_rxcnt_read: assert property (@(posedge ref_clk) disable iff (!rstn)
      (reg_rd && reg_addr == 4'h8) |=> (reg_rdata == $past(rx_fill))) else $error("rx count read wrong");
endmodule : umsb_top
`default_nettype wire

// ---- pkg/umsb_cfg.svh ----
/*
 Register offsets, field positions, reset values and timing counts for the UART modem, status and baud block.
 Assumes it is included by bare name in the package and in the design files.
*/
`ifndef UMSB_CFG_SVH
`define UMSB_CFG_SVH
`define UMSB_OFS_DIV_LOW   4'h0
`define UMSB_OFS_DIV_HIGH  4'h1
`define UMSB_OFS_DIV_FRAC  4'h2
`define UMSB_OFS_LCTRL     4'h3
`define UMSB_OFS_MCTRL     4'h4
`define UMSB_OFS_LSTAT     4'h5
`define UMSB_OFS_MSTAT     4'h6
`define UMSB_OFS_RXCNT     4'h8
`define UMSB_OFS_TXCNT     4'h9
`define UMSB_OFS_DATA      4'h0
`define UMSB_RST_BYTE      8'h00
`define UMSB_RST_LCTRL     8'h03
`define UMSB_BIT_LOOP      4
`define UMSB_BIT_AUX2      3
`define UMSB_BIT_AUX1      2
`define UMSB_BIT_RTS       1
`define UMSB_BIT_DTR       0
`define UMSB_BIT_DIVSEL    7
`define UMSB_OVERSAMPLE    5'h10
`define UMSB_FIFO_DEPTH    8
`endif

// ---- pkg/umsb_pkg.sv ----
/*
 Types for the UART modem, status and baud block.
 Assumes umsb_cfg.svh is on the include path.
*/
`include "umsb_cfg.svh"
package umsb_pkg;
   typedef enum logic [1:0] {
      UMSB_IDLE  = 2'b00,
      UMSB_START = 2'b01,
      UMSB_DATA  = 2'b10,
      UMSB_STOP  = 2'b11
   } umsb_ser_t;
endpackage : umsb_pkg

// ---- verilog/umsb_fifo.sv ----
/*
 Flip-flop FIFO with valid and ready on both sides and a fill count.
 Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/10ps
`default_nettype none
module umsb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [7:0]       fill
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               rd;
      logic [AW-1:0]               wr;
      logic [AW:0]                 cnt;
   } umsb_fifo_st_t;
   umsb_fifo_st_t st_reg;
   umsb_fifo_st_t st_next;
   logic          push;
   logic          pop;

   // Handshakes and outputs
   assign in_ready  = (st_reg.cnt != (AW+1)'(DEPTH));
   assign out_valid = (st_reg.cnt != '0);
   assign out_data  = st_reg.mem[st_reg.rd];
   assign fill      = 8'(st_reg.cnt);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointer and storage update
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wr] = in_data;
         st_next.wr = st_reg.wr + 1'b1;
      end
      if (pop) begin
         st_next.rd = st_reg.rd + 1'b1;
      end
      st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (flush) begin
         st_next.rd  = '0;
         st_next.wr  = '0;
         st_next.cnt = '0;
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : umsb_fifo
`default_nettype wire

// ---- bench/umsb_term.sv ----
/*
 Remote serial terminal model: sends bit frames on the receive line, decodes 8-bit frames from the transmit line,
 drives the four modem lines.
 Assumes sixteen reference cycles per bit (integer divisor one, no fraction) and 8 data bits, 1 stop bit.
*/
`timescale 1ns/10ps
`default_nettype none
module umsb_term (
   input  wire logic ref_clk,
   input  wire logic txd,
   output logic      rxd,
   output logic      cts_n,
   output logic      dsr_n,
   output logic      ri_n,
   output logic      dcd_n
);
   logic [7:0] got_q [$];
   logic [7:0] rx_byte;

   // Line idles high, driven by the model, modem lines idle inactive
   initial begin
      rxd = 1'b1;
      {dcd_n, ri_n, dsr_n, cts_n} = 4'hf;
   end

   // Drive the modem pins, order carrier, ring, set-ready, clear-to-send
   task automatic set_pins(input logic [3:0] v);
      @(posedge ref_clk);
      {dcd_n, ri_n, dsr_n, cts_n} <= v;
   endtask : set_pins

   // Send n bits, lowest first, sixteen cycles each, then release to idle
   task automatic send(input logic [11:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         rxd <= bits[i];
         repeat (15) @(posedge ref_clk);
      end
      @(posedge ref_clk);
      rxd <= 1'b1;
   endtask : send

   // Sample each bit in its middle and keep the data byte
   always begin
      @(negedge txd);
      repeat (8) @(posedge ref_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (16) @(posedge ref_clk);
         rx_byte[i] = txd;
      end
      repeat (16) @(posedge ref_clk);
      got_q.push_back(rx_byte);
   end
endmodule : umsb_term
`default_nettype wire

// ---- bench/uart_modem_status_baud_tb.sv ----
/*
 Self-checking bench for the modem, status and baud block, with a terminal model on the serial side.
 Assumes the byte-wide register port with one-cycle strobes and read data one cycle after the strobe.
*/
`timescale 1ns/10ps
`default_nettype none
module uart_modem_status_baud_tb;
   logic       ref_clk, rstn, reg_wr, reg_rd, txd, rxd, rts_n, dtr_n, cts_n, dsr_n, ri_n, dcd_n;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, d, b;
   logic [3:0] p, lvl;
   logic [7:0] sent_q [$];
   int         n_mismatch = 0;
   int         n_compared = 0;

   umsb_top DUT (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .txd(txd), .rxd(rxd), .rts_n(rts_n), .dtr_n(dtr_n),
      .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n));
   umsb_term term (.ref_clk(ref_clk), .txd(txd), .rxd(rxd), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
      .dcd_n(dcd_n));

   // 25 MHz reference clock
   always #20 ref_clk = ~ref_clk;

   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : close_out

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
      #1;
   endtask : wr

   // Read one register, mask it and compare
   task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string what);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      chk(what, reg_rdata & m, e);
   endtask : rchk

   // Expected modem status from new and old levels: carrier, ring, set-ready, clear-to-send
   function automatic logic [7:0] msr_exp(input logic [3:0] nw, input logic [3:0] od);
      return {nw, nw[3] ^ od[3], nw[2] & ~od[2], nw[1] ^ od[1], nw[0] ^ od[0]};
   endfunction : msr_exp

   // Hang guard, well above the run length
   initial begin
      repeat (30000) @(posedge ref_clk);
      n_mismatch++;
      close_out();
   end

   // Main sequence
   initial begin
      ref_clk = 1'b0; rstn = 1'b0; reg_addr = 4'h0; reg_wr = 1'b0; reg_rd = 1'b0; reg_wdata = 8'h00;
      void'($urandom(19256));
      repeat (10) @(posedge ref_clk);
      rstn <= 1'b1;
      rchk(4'h5, 8'hff, 8'h60, "status after reset");
      rchk(4'h8, 8'hff, 8'h00, "rx count after reset");
      rchk(4'h9, 8'hff, 8'h00, "tx count after reset");
      // Divisor bytes: a write with select clear must miss them
      wr(4'h1, 8'hff);
      wr(4'h3, 8'h83);
      // divisor one gives sixteen cycles per bit
      wr(4'h0, 8'h01);
      wr(4'h2, 8'h00);
      rchk(4'h0, 8'hff, 8'h01, "divisor low");
      rchk(4'h1, 8'hff, 8'h00, "divisor high");
      rchk(4'h2, 8'hff, 8'h00, "divisor fraction");
      wr(4'h3, 8'h03);
      // Modem outputs and status
      rchk(4'h6, 8'h00, 8'h00, "status clear read");
      lvl = 4'h0;
      wr(4'h4, 8'h03);
      chk("modem outputs on", {6'h0, rts_n, dtr_n}, 8'h00);
      wr(4'h4, 8'h00);
      chk("modem outputs off", {6'h0, rts_n, dtr_n}, 8'h03);
      for (int i = 0; i < 8; i++) begin
         p = (i == 0) ? 4'h0 : 4'($urandom);
         term.set_pins(p);
         repeat (4) @(posedge ref_clk);
         rchk(4'h6, 8'hff, msr_exp(~p, lvl), "modem status");
         lvl = ~p;
         rchk(4'h6, 8'hff, {lvl, 4'h0}, "change flags cleared");
      end
      term.set_pins(4'hf);
      repeat (4) @(posedge ref_clk);
      rchk(4'h6, 8'h00, 8'h00, "status clear read");
      // Loopback: pins held, modem bits and data wrapped
      wr(4'h4, 8'h1f);
      chk("loop outputs", {5'h0, txd, rts_n, dtr_n}, 8'h07);
      rchk(4'h6, 8'h00, 8'h00, "status clear read");
      rchk(4'h6, 8'hff, 8'hf0, "loop levels high");
      wr(4'h4, 8'h10);
      rchk(4'h6, 8'hff, msr_exp(4'h0, 4'hf), "loop levels low");
      b = 8'($urandom);
      wr(4'h0, b);
      repeat (200) @(posedge ref_clk);
      rchk(4'h8, 8'hff, 8'h01, "rx count loop");
      rchk(4'h5, 8'hff, 8'h61, "status loop");
      rchk(4'h0, 8'hff, b, "loop data");
      chk("line held high", {7'h0, txd}, 8'h01);
      chk("terminal idle", 8'(term.got_q.size()), 8'h00);
      // Normal transmit: fill past the FIFO
      wr(4'h4, 8'h00);
      for (int i = 0; i < 9; i++) begin
         b = 8'($urandom);
         sent_q.push_back(b);
         wr(4'h0, b);
      end
      rchk(4'h9, 8'hff, 8'h08, "tx count full");
      rchk(4'h5, 8'h60, 8'h00, "tx busy");
      repeat (1500) @(posedge ref_clk);
      rchk(4'h5, 8'h60, 8'h60, "tx drained");
      rchk(4'h9, 8'hff, 8'h00, "tx count empty");
      chk("tx frames", 8'(term.got_q.size()), 8'h09);
      foreach (sent_q[i]) chk("tx byte", term.got_q[i], sent_q[i]);
      // Receive past the FIFO: overrun
      sent_q.delete();
      for (int i = 0; i < 10; i++) begin
         b = 8'($urandom);
         sent_q.push_back(b);
         term.send({3'b111, b, 1'b0}, 10);
      end
      repeat (20) @(posedge ref_clk);
      rchk(4'h8, 8'hff, 8'h08, "rx count full");
      rchk(4'h5, 8'hff, 8'h63, "overrun");
      rchk(4'h5, 8'hff, 8'h61, "overrun cleared");
      for (int i = 0; i < 8; i++) rchk(4'h0, 8'hff, sent_q[i], "rx data");
      rchk(4'h5, 8'hff, 8'h60, "rx drained");
      // Line errors
      term.send({3'b110, 8'h55, 1'b0}, 10);
      repeat (20) @(posedge ref_clk);
      rchk(4'h5, 8'h9e, 8'h88, "framing error");
      rchk(4'h5, 8'h9e, 8'h00, "framing cleared");
      term.send(12'h000, 11);
      repeat (200) @(posedge ref_clk);
      rchk(4'h5, 8'h90, 8'h90, "break");
      rchk(4'h5, 8'h90, 8'h00, "break cleared");
      wr(4'h3, 8'h1b);
      term.send({2'b11, 1'b0, 8'h01, 1'b0}, 11);
      repeat (20) @(posedge ref_clk);
      rchk(4'h5, 8'h84, 8'h84, "parity error");
      rchk(4'h5, 8'h84, 8'h00, "parity cleared");
      close_out();
   end
endmodule : uart_modem_status_baud_tb
`default_nettype wire
